// >>> design/usw_control.sv
// universal serial unit: counter, flags, wire modes and pin drive behind axi4-lite
`timescale 1ns/10ps
`default_nettype none
module usw_control (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [usw_pkg::AW-1:0] s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [usw_pkg::DW-1:0] s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [usw_pkg::AW-1:0] s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [usw_pkg::DW-1:0]    s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 serial_in_pin_i,
    input  wire logic                 serial_clock_pin_i,
    input  wire logic                 timer_match,
    output logic                      serial_in_pin_o,
    output logic                      serial_in_pin_oe,
    output logic                      serial_in_pull_en,
    output logic                      serial_clock_pin_o,
    output logic                      serial_clock_pin_oe,
    output logic                      serial_clock_pull_en,
    output logic                      data_out_pin_o,
    output logic                      data_out_pin_oe,
    output logic                      data_out_pull_en,
    output logic                      start_irq_req,
    output logic                      count_wrap_irq_req,
    output logic                      wake_idle
);
    import usw_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic sda_m_r, sda_s_r, sda_d_r;
    logic scl_m_r, scl_s_r, scl_d_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_d_r <= 1'b1;
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_d_r <= 1'b1;
        end else begin
            sda_m_r <= serial_in_pin_i;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
            scl_m_r <= serial_clock_pin_i;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
        end
    end

    logic sda_rise, sda_fall, scl_rise, scl_fall;
    assign sda_rise = sda_s_r & ~sda_d_r;
    assign sda_fall = ~sda_s_r & sda_d_r;
    assign scl_rise = scl_s_r & ~scl_d_r;
    assign scl_fall = ~scl_s_r & scl_d_r;

    // ----------------------------------------
    // axi4-lite write channel
    // ----------------------------------------
    logic            aw_hold_r, w_hold_r, bvalid_r;
    logic [AW-1:0]   awaddr_r;
    logic [DW-1:0]   wdata_r;
    logic [3:0]      wstrb_r;
    logic [1:0]      bresp_r;
    logic            do_wr, wr_en;
    logic [AW-1:0]   wr_word;

    assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
    assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign do_wr   = aw_hold_r & w_hold_r & ~bvalid_r;
    assign wr_en   = do_wr & wstrb_r[0];
    assign wr_word = {awaddr_r[AW-1:2], 2'h0};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= '0;
            wstrb_r   <= '0;
            bresp_r   <= RESP_OK;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= usw_addr_ok(awaddr_r) ? RESP_OK : RESP_ERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    logic wr_ctrl, wr_stat, wr_port, wr_data;
    assign wr_ctrl = wr_en & (wr_word == ADDR_CTRL);
    assign wr_stat = wr_en & (wr_word == ADDR_STAT);
    assign wr_port = wr_en & (wr_word == ADDR_PORT);
    assign wr_data = wr_en & (wr_word == ADDR_DATA);

    // ----------------------------------------
    // control and port registers
    // ----------------------------------------
    logic       sie_r, oie_r, clk_sel_r;
    usw_wm_t    wm_r;
    usw_cs_t    cs_r;
    logic [7:0] port_r;
    logic       tc_strobe, two_wire, ext_src;

    assign tc_strobe = wr_ctrl & wdata_r[C_TC];
    assign two_wire  = usw_two_wire(wm_r);
    assign ext_src   = cs_r[1];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sie_r     <= 1'b0;
            oie_r     <= 1'b0;
            wm_r      <= WM_OFF;
            cs_r      <= CS_SOFT;
            clk_sel_r <= 1'b0;
        end else if (wr_ctrl) begin
            sie_r     <= wdata_r[C_SIE];
            oie_r     <= wdata_r[C_OIE];
            wm_r      <= wdata_r[C_WM +: 2];
            cs_r      <= wdata_r[C_CS +: 2];
            clk_sel_r <= wdata_r[C_CLK];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_r <= RST8;
        end else if (wr_port) begin
            port_r <= wdata_r[7:0];
        end else if (tc_strobe) begin
            port_r[P_CKP] <= ~port_r[P_CKP];
        end
    end

    // ----------------------------------------
    // clock source selection
    // ----------------------------------------
    logic soft_strobe, cnt_tick, shift_tick, scl_edge;
    assign scl_edge    = scl_rise | scl_fall;
    assign soft_strobe = wr_ctrl & wdata_r[C_CLK] & (cs_r == CS_SOFT);
    // counter source; inputs act the same whatever the wire mode
    assign cnt_tick = soft_strobe
                    | ((cs_r == CS_TIMER) & timer_match)
                    | (ext_src & ~clk_sel_r & scl_edge)
                    | (ext_src & clk_sel_r & tc_strobe);
    assign shift_tick = soft_strobe
                      | ((cs_r == CS_TIMER) & timer_match)
                      | (ext_src & (cs_r[0] ? scl_fall : scl_rise));

    // ----------------------------------------
    // shift register and counter
    // ----------------------------------------
    logic [7:0] shift_r;
    logic [3:0] cnt_r;
    logic       wrap;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_r <= RST8;
        end else if (wr_data) begin
            shift_r <= wdata_r[7:0];
        end else if (shift_tick) begin
            shift_r <= {shift_r[6:0], sda_s_r};
        end
    end

    // a software write of the count beats a tick in the same cycle
    assign wrap = cnt_tick & ~wr_stat & (cnt_r == CNT_MAX);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= RST8[3:0];
        end else if (wr_stat) begin
            cnt_r <= wdata_r[3:0];
        end else if (cnt_tick) begin
            cnt_r <= cnt_r + CNT_ONE;
        end
    end

    // ----------------------------------------
    // flags and clock holds
    // ----------------------------------------
    logic sif_r, oif_r, pf_r, start_hold_r, wrap_hold_r;
    logic start_evt, stop_evt, sif_clr, oif_clr, pf_clr;

    assign sif_clr   = wr_stat & wdata_r[S_SIF];
    assign oif_clr   = wr_stat & wdata_r[S_OIF];
    assign pf_clr    = wr_stat & wdata_r[S_PF];
    assign start_evt = (two_wire & sda_fall & scl_s_r)
                     | (~two_wire & ext_src & ~clk_sel_r & scl_edge);
    assign stop_evt  = two_wire & sda_rise & scl_s_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sif_r <= 1'b0;
            oif_r <= 1'b0;
            pf_r  <= 1'b0;
        end else begin
            sif_r <= start_evt | (sif_r & ~sif_clr);
            oif_r <= wrap | (oif_r & ~oif_clr);
            pf_r  <= stop_evt | (pf_r & ~pf_clr);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_hold_r <= 1'b0;
        end else if (sif_clr && !start_evt) begin
            start_hold_r <= 1'b0;
        end else if (sif_r && two_wire && scl_fall) begin
            start_hold_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wrap_hold_r <= 1'b0;
        end else if (oif_clr && !wrap) begin
            wrap_hold_r <= 1'b0;
        end else if (wrap && wm_r == WM_2WH) begin
            wrap_hold_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    logic sda_o_nxt, sda_oe_nxt, sda_pu_nxt;
    logic scl_o_nxt, scl_oe_nxt, scl_pu_nxt;
    logic do_o_nxt, do_oe_nxt, do_pu_nxt, scl_hold;

    assign scl_hold = start_hold_r | (wrap_hold_r & (wm_r == WM_2WH));

    always_comb begin
        sda_o_nxt  = port_r[P_DIP];
        sda_oe_nxt = port_r[P_DID];
        sda_pu_nxt = ~port_r[P_DID] & port_r[P_DIP];
        scl_o_nxt  = port_r[P_CKP];
        scl_oe_nxt = port_r[P_CKD];
        scl_pu_nxt = ~port_r[P_CKD] & port_r[P_CKP];
        do_o_nxt   = port_r[P_DOP];
        do_oe_nxt  = port_r[P_DOD];
        do_pu_nxt  = ~port_r[P_DOD] & port_r[P_DOP];
        if (wm_r == WM_3W) begin
            do_o_nxt = shift_r[7];
        end
        if (two_wire) begin
            sda_o_nxt  = 1'b0;
            sda_oe_nxt = port_r[P_DID] & (~shift_r[7] | ~port_r[P_DIP]);
            sda_pu_nxt = 1'b0;
            scl_o_nxt  = 1'b0;
            scl_oe_nxt = port_r[P_CKD] & (~port_r[P_CKP] | scl_hold);
            scl_pu_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_in_pin_o      <= 1'b0;
            serial_in_pin_oe     <= 1'b0;
            serial_in_pull_en    <= 1'b0;
            serial_clock_pin_o   <= 1'b0;
            serial_clock_pin_oe  <= 1'b0;
            serial_clock_pull_en <= 1'b0;
            data_out_pin_o       <= 1'b0;
            data_out_pin_oe      <= 1'b0;
            data_out_pull_en     <= 1'b0;
        end else begin
            serial_in_pin_o      <= sda_o_nxt;
            serial_in_pin_oe     <= sda_oe_nxt;
            serial_in_pull_en    <= sda_pu_nxt;
            serial_clock_pin_o   <= scl_o_nxt;
            serial_clock_pin_oe  <= scl_oe_nxt;
            serial_clock_pull_en <= scl_pu_nxt;
            data_out_pin_o       <= do_o_nxt;
            data_out_pin_oe      <= do_oe_nxt;
            data_out_pull_en     <= do_pu_nxt;
        end
    end

    // ----------------------------------------
    // interrupt requests
    // ----------------------------------------
    assign start_irq_req      = sif_r & sie_r & port_r[P_GIE];
    assign count_wrap_irq_req = oif_r & oie_r & port_r[P_GIE];
    assign wake_idle          = count_wrap_irq_req;

    // ----------------------------------------
    // axi4-lite read channel
    // ----------------------------------------
    logic       rvalid_r;
    logic [1:0] rresp_r;
    logic [7:0] rd_byte;
    logic [DW-1:0] rdata_r;
    logic       collision;

    assign collision     = shift_r[7] ^ sda_s_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    always_comb begin
        case ({s_axi_araddr[AW-1:2], 2'h0})
            ADDR_CTRL: rd_byte = {sie_r, oie_r, wm_r, cs_r, 2'h0};
            ADDR_STAT: rd_byte = {sif_r, oif_r, pf_r, collision, cnt_r};
            ADDR_PORT: rd_byte = port_r;
            ADDR_DATA: rd_byte = shift_r;
            default:   rd_byte = RST8;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r  <= RESP_OK;
            rdata_r  <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rresp_r  <= usw_addr_ok(s_axi_araddr) ? RESP_OK : RESP_ERR;
            rdata_r  <= {24'h000000, rd_byte};
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_held_start;
        two_wire && port_r[P_CKD] && start_hold_r;
    endsequence
    sequence s_pending_wrap_en;
        wr_ctrl && wdata_r[C_OIE] && oif_r && port_r[P_GIE] && !oif_clr;
    endsequence

    a_wrap_sets_flag: assert property (wrap |=> oif_r)
        else $error("wrap did not set flag");
    a_wrap_flag_keep: assert property (oif_r && !oif_clr |=> oif_r)
        else $error("wrap flag lost without clear");
    a_wrap_irq_now: assert property (s_pending_wrap_en |=> count_wrap_irq_req)
        else $error("pending wrap not raised on enable");
    a_stop_sets: assert property (stop_evt |=> pf_r)
        else $error("stop flag not set");
    a_cnt_write: assert property (wr_stat |=> cnt_r == $past(wdata_r[3:0]))
        else $error("count write not taken");
    a_cnt_step: assert property (cnt_tick && !wr_stat |=> cnt_r == 4'($past(cnt_r) + CNT_ONE))
        else $error("count did not advance");
    a_tc_toggles: assert property (tc_strobe |=> port_r[P_CKP] != $past(port_r[P_CKP]))
        else $error("toggle strobe failed");
    a_scl_held: assert property (s_held_start |=> serial_clock_pin_oe && !serial_clock_pin_o)
        else $error("clock not held after start");
    a_pull_off: assert property (two_wire |=> !serial_in_pull_en && !serial_clock_pull_en)
        else $error("pull-up on in two-wire");
    a_off_ports: assert property (wm_r == WM_OFF |=> serial_clock_pin_o == $past(port_r[P_CKP])
                                  && serial_in_pin_oe == $past(port_r[P_DID]))
        else $error("mode zero pin not under port");
    a_wrap_hold: assert property (wrap && wm_r == WM_2WH ##1 (!oif_clr && port_r[P_CKD] && wm_r == WM_2WH)
                                  |=> serial_clock_pin_oe)
        else $error("clock not held after wrap");
endmodule : usw_control
`default_nettype wire

// >>> pkg/usw_pkg.sv
// constants and field layout of the universal serial unit control block
package usw_pkg;
    localparam int unsigned AW = 12;
    localparam int unsigned DW = 32;
    // register indices; byte address is four times the index
    localparam logic [7:0]    IDX_CTRL  = 8'hB8;
    localparam logic [7:0]    IDX_STAT  = 8'hB9;
    localparam logic [7:0]    IDX_PORT  = 8'hBA;
    localparam logic [7:0]    IDX_DATA  = 8'hBB;
    localparam logic [AW-1:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [AW-1:0] ADDR_STAT = {2'h0, IDX_STAT, 2'h0};
    localparam logic [AW-1:0] ADDR_PORT = {2'h0, IDX_PORT, 2'h0};
    localparam logic [AW-1:0] ADDR_DATA = {2'h0, IDX_DATA, 2'h0};
    // serial_control fields
    localparam int unsigned C_SIE = 7;
    localparam int unsigned C_OIE = 6;
    localparam int unsigned C_WM  = 4;
    localparam int unsigned C_CS  = 2;
    localparam int unsigned C_CLK = 1;
    localparam int unsigned C_TC  = 0;
    // serial_status fields
    localparam int unsigned S_SIF = 7;
    localparam int unsigned S_OIF = 6;
    localparam int unsigned S_PF  = 5;
    localparam int unsigned S_DC  = 4;
    // pin_port fields
    localparam int unsigned P_CKP = 0;
    localparam int unsigned P_CKD = 1;
    localparam int unsigned P_DIP = 2;
    localparam int unsigned P_DID = 3;
    localparam int unsigned P_DOP = 4;
    localparam int unsigned P_DOD = 5;
    localparam int unsigned P_GIE = 7;
    localparam logic [7:0]    RST8     = 8'h00;
    localparam logic [3:0]    CNT_MAX  = 4'hF;
    localparam logic [3:0]    CNT_ONE  = 4'h1;
    localparam logic [1:0]    RESP_OK  = 2'h0;
    localparam logic [1:0]    RESP_ERR = 2'h2;
    typedef logic [1:0] usw_wm_t;
    localparam usw_wm_t WM_OFF = 2'h0;
    localparam usw_wm_t WM_3W  = 2'h1;
    localparam usw_wm_t WM_2W  = 2'h2;
    localparam usw_wm_t WM_2WH = 2'h3;
    typedef logic [1:0] usw_cs_t;
    localparam usw_cs_t CS_SOFT  = 2'h0;
    localparam usw_cs_t CS_TIMER = 2'h1;

    function automatic logic usw_two_wire(input usw_wm_t wm);
        return (wm == WM_2W) || (wm == WM_2WH);
    endfunction : usw_two_wire

    function automatic logic usw_addr_ok(input logic [AW-1:0] a);
        logic [AW-1:0] w;
        w = {a[AW-1:2], 2'h0};
        return (w == ADDR_CTRL) || (w == ADDR_STAT) || (w == ADDR_PORT) || (w == ADDR_DATA);
    endfunction : usw_addr_ok
endpackage : usw_pkg

// >>> tb/usw_partner.sv
// far-side two-wire master model with open-drain lines and pull-ups
`timescale 1ns/10ps
`default_nettype none
module usw_partner (
    input  wire logic sda_o,
    input  wire logic sda_oe,
    input  wire logic scl_o,
    input  wire logic scl_oe,
    output logic      sda_line,
    output logic      scl_line
);
    logic m_sda = 1'b1;
    logic m_scl = 1'b1;
    // a released line floats to the pull-up level
    assign sda_line = m_sda & !(sda_oe & !sda_o);
    assign scl_line = m_scl & !(scl_oe & !scl_o);
    // clock runs only while the pulses task runs, 80 ns period
    task automatic pulses(input int n);
        repeat (n) begin
            #40 m_scl = 1'b0;
            #40 m_scl = 1'b1;
        end
    endtask : pulses
    task automatic start_cond();
        m_sda = 1'b0;
        #40 m_scl = 1'b0;
        #40;
    endtask : start_cond
    task automatic stop_cond();
        int k;
        k = 0;
        m_sda = 1'b0;
        m_scl = 1'b1;
        // the slave may still stretch the clock low
        while (!scl_line && k < 100) begin
            #10 k++;
        end
        #40 m_sda = 1'b1;
        #40;
    endtask : stop_cond
endmodule : usw_partner
`default_nettype wire

// >>> tb/usw_control_tb.sv
// self-checking bench for the universal serial unit control block
`timescale 1ns/10ps
`default_nettype none
module usw_control_tb;
    import usw_pkg::*;
    logic          aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tm;
    logic [AW-1:0] awaddr, araddr;
    logic [DW-1:0] wdata, rdata;
    logic [3:0]    wstrb;
    logic [1:0]    bresp, rresp, r;
    logic [7:0]    v;
    logic          awready, wready, bvalid, arready, rvalid, sirq, wirq, wake, sda, scl;
    logic          sda_o, sda_oe, sda_pu, scl_o, scl_oe, scl_pu, do_o, do_oe, do_pu;
    int            err_total = 0;
    int            num_checks = 0;
    int            cyc = 0;
    usw_control i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .serial_in_pin_i(sda), .serial_clock_pin_i(scl),
        .timer_match(tm), .serial_in_pin_o(sda_o), .serial_in_pin_oe(sda_oe),
        .serial_in_pull_en(sda_pu), .serial_clock_pin_o(scl_o),
        .serial_clock_pin_oe(scl_oe), .serial_clock_pull_en(scl_pu),
        .data_out_pin_o(do_o), .data_out_pin_oe(do_oe), .data_out_pull_en(do_pu),
        .start_irq_req(sirq), .count_wrap_irq_req(wirq), .wake_idle(wake));
    usw_partner i_far (.sda_o(sda_o), .sda_oe(sda_oe), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_line(sda), .scl_line(scl));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end
    task automatic results();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
        logic ha, hw, pb;
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        pb = 1'b1;
        while (pb) begin
            @(negedge aclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            pb = !(bvalid && bready);
            @(posedge aclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (!pb) bready <= 1'b0;
        end
        // let registered pin outputs settle before callers look at them
        #1;
    endtask : wr
    task automatic rd(input logic [AW-1:0] a, output logic [7:0] d, output logic [1:0] rs);
        logic ha, pr;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        pr = 1'b1;
        while (pr) begin
            @(negedge aclk);
            ha = arvalid && arready;
            pr = !(rvalid && rready);
            d  = rdata[7:0];
            rs = rresp;
            @(posedge aclk);
            if (ha) arvalid <= 1'b0;
            if (!pr) rready <= 1'b0;
        end
        #1;
    endtask : rd
    task automatic tick(input int n);
        repeat (n) begin
            tm <= 1'b1;
            @(posedge aclk);
            tm <= 1'b0;
            @(posedge aclk);
        end
        #1;
    endtask : tick
    task automatic t_reset();
        rd(ADDR_CTRL, v, r);
        chk(v, 8'h00);
        rd(ADDR_STAT, v, r);
        chk(v & 8'hEF, 8'h00);
        rd(12'h000, v, r);
        chk({6'h0, r}, {6'h0, RESP_ERR});
    endtask : t_reset
    task automatic t_wrap();
        wr(ADDR_PORT, 8'h80);
        wr(ADDR_STAT, 8'h0F);
        rd(ADDR_STAT, v, r);
        chk(v & 8'hEF, 8'h0F);
        wr(ADDR_CTRL, 8'h02);
        rd(ADDR_STAT, v, r);
        chk(v & 8'hEF, 8'h40);
        rd(ADDR_DATA, v, r);
        chk(v, 8'h01);
        chk({7'h0, wirq}, 8'h00);
        wr(ADDR_CTRL, 8'h40);
        chk({6'h0, wirq, wake}, 8'h03);
        wr(ADDR_STAT, 8'h40);
        rd(ADDR_STAT, v, r);
        chk({6'h0, v[6], wirq}, 8'h00);
    endtask : t_wrap
    task automatic t_counts();
        wr(ADDR_CTRL, 8'h04);
        tick(3);
        rd(ADDR_STAT, v, r);
        chk(v & 8'h0F, 8'h03);
        wr(ADDR_CTRL, 8'h0A);
        wr(ADDR_CTRL, 8'h0B);
        rd(ADDR_PORT, v, r);
        chk(v & 8'h01, 8'h01);
        wr(ADDR_CTRL, 8'h0B);
        rd(ADDR_STAT, v, r);
        chk(v & 8'h0F, 8'h05);
        rd(ADDR_CTRL, v, r);
        chk(v, 8'h08);
        wr(ADDR_CTRL, 8'h08);
        wr(ADDR_STAT, 8'h00);
        i_far.pulses(3);
        repeat (4) @(posedge aclk);
        rd(ADDR_STAT, v, r);
        chk(v & 8'h8F, 8'h86);
        chk({6'h0, scl_oe, sda_oe}, 8'h00);
        wr(ADDR_STAT, 8'h80);
    endtask : t_counts
    task automatic t_two_wire();
        wr(ADDR_DATA, 8'hFF);
        wr(ADDR_PORT, 8'h85);
        chk({6'h0, sda_pu, scl_pu}, 8'h03);
        wr(ADDR_CTRL, 8'h20);
        chk({6'h0, sda_pu, scl_pu}, 8'h00);
        wr(ADDR_PORT, 8'h8F);
        chk({6'h0, sda_oe, scl_oe}, 8'h00);
        i_far.start_cond();
        repeat (4) @(posedge aclk);
        rd(ADDR_STAT, v, r);
        chk(v & 8'h90, 8'h90);
        chk({6'h0, scl_oe, scl_o}, 8'h02);
        wr(ADDR_CTRL, 8'hA0);
        chk({7'h0, sirq}, 8'h01);
        wr(ADDR_STAT, 8'h80);
        chk({6'h0, scl_oe, sirq}, 8'h00);
        i_far.stop_cond();
        repeat (4) @(posedge aclk);
        rd(ADDR_STAT, v, r);
        chk({5'h0, v[5], sirq, wirq}, 8'h04);
        wr(ADDR_STAT, 8'h20);
        wr(ADDR_DATA, 8'h00);
        chk({6'h0, sda_oe, sda_o}, 8'h02);
    endtask : t_two_wire
    task automatic t_hold();
        wr(ADDR_DATA, 8'hFF);
        // clear the start flag left by the last data low, so no start hold joins in
        wr(ADDR_STAT, 8'hEF);
        wr(ADDR_CTRL, 8'h34);
        tick(1);
        @(posedge aclk);
        chk({6'h0, scl_oe, scl_o}, 8'h02);
        wr(ADDR_STAT, 8'h40);
        chk({7'h0, scl_oe}, 8'h00);
        wr(ADDR_CTRL, 8'h00);
        chk({5'h0, scl_oe, sda_oe, do_oe}, 8'h06);
    endtask : t_hold
    task automatic t_three();
        wr(ADDR_PORT, 8'hA0);
        wr(ADDR_DATA, 8'h80);
        wr(ADDR_CTRL, 8'h10);
        chk({6'h0, do_oe, do_o}, 8'h03);
        wr(ADDR_DATA, 8'h00);
        chk({6'h0, do_oe, do_o}, 8'h02);
        wr(ADDR_PORT, 8'h90);
        chk({6'h0, do_oe, do_pu}, 8'h01);
    endtask : t_three
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, tm} = 6'h00;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_wrap();
        t_counts();
        t_two_wire();
        t_hold();
        t_three();
        results();
    end
endmodule : usw_control_tb
`default_nettype wire
